// [logic/fcs_seq.sv]
// command sequencer of the on-chip flash: decodes cpu write sequences, runs
// program, erase and protect operations, answers reads with array, id or toggle data
// assumes the cpu bus gives one-cycle read and write strobes on core_clk
`timescale 1ns/1ns
module fcs_seq #(
  parameter int ARRAY_KB = fcs_pkg::ARRAY_KB,
  parameter int CHIP_CYC = fcs_pkg::ERASE_CYC,
  parameter int SECT_CYC = fcs_pkg::SECT_CYC,
  // arbitrary neutral identity values
  parameter logic [7:0] MAKER_CODE = 8'h5A,
  parameter logic [7:0] MACRO_CODE = 8'h3C
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic [3:0] command_enable_key,
  input wire logic par_mode_pin,
  input wire logic loader_mode_pin,
  output logic flash_busy,
  output logic array_unavail,
  output logic read_protected,
  output logic serial_cmd_refuse,
  output logic wdt_hold_off
);
  localparam int DEPTH = ARRAY_KB * 1024;
  localparam logic [16:0] TOP = 17'h10000;
  localparam logic [16:0] BASE17 = TOP - 17'(DEPTH);
  localparam logic [15:0] SECT_LEN = 16'(fcs_pkg::SECT_BYTES);
  localparam int CW = fcs_pkg::CNT_W;
  localparam logic [fcs_pkg::CNT_W-1:0] PROG_N = CW'(fcs_pkg::PROG_CYC);
  localparam logic [fcs_pkg::CNT_W-1:0] PROT_N = CW'(fcs_pkg::PROT_CYC);
  localparam logic [fcs_pkg::CNT_W-1:0] CHIP_N = CW'(CHIP_CYC);
  localparam logic [fcs_pkg::CNT_W-1:0] SECT_N = CW'(SECT_CYC);
  localparam logic [fcs_pkg::CNT_W-1:0] CNT_ONE = CW'(1);
  localparam logic [fcs_pkg::CNT_W-1:0] CNT_ZERO = '0;

  fcs_pkg::fcs_seq_t seq_r, seq_nxt;
  fcs_pkg::fcs_op_t op_r;
  logic [fcs_pkg::CNT_W-1:0] cnt_r;
  logic busy_r, tog_r, id_mode_r, prot_r;
  logic walk_r;
  logic [16:0] walk_ptr_r, walk_end_r;
  logic par_s1_r, par_s2_r, ldr_s1_r, ldr_s2_r;
  logic rd_p1_r;
  logic [1:0] rsel_p1_r;
  logic [7:0] alt_p1_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic [7:0] mem_q;

  // pins from outside the clock domain
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      par_s1_r <= 1'b0;
      par_s2_r <= 1'b0;
      ldr_s1_r <= 1'b0;
      ldr_s2_r <= 1'b0;
    end else begin
      par_s1_r <= par_mode_pin;
      par_s2_r <= par_s1_r;
      ldr_s1_r <= loader_mode_pin;
      ldr_s2_r <= ldr_s1_r;
    end
  end

  // command write decode
  wire key_ok = (command_enable_key == fcs_pkg::KEY_ENABLE); // RULE_22
  wire cmd_wr = bus_wr && key_ok && !busy_r; // RULE_03 RULE_14
  wire [11:0] low_addr = bus_addr[11:0]; // RULE_21
  wire is_u1 = (low_addr == fcs_pkg::ADDR_U1) && (bus_wdata == fcs_pkg::DAT_U1);
  wire is_u2 = (low_addr == fcs_pkg::ADDR_U2) && (bus_wdata == fcs_pkg::DAT_U2);
  wire at_u1 = (low_addr == fcs_pkg::ADDR_U1);
  wire prot_step = (bus_addr == fcs_pkg::ADDR_PROT) && (bus_wdata == fcs_pkg::DAT_PROT_CONF);
  wire in_array = ({1'b0, bus_addr} >= BASE17);
  wire start_prog = cmd_wr && (seq_r == fcs_pkg::SEQ_PGM) && in_array; // RULE_23
  wire start_chip = cmd_wr && (seq_r == fcs_pkg::SEQ_E3) && at_u1
    && (bus_wdata == fcs_pkg::DAT_CHIP);
  // a sector below the array would otherwise make the walk touch the first array byte
  wire start_sect = cmd_wr && (seq_r == fcs_pkg::SEQ_E3) && in_array
    && (bus_wdata == fcs_pkg::DAT_SECT); // RULE_17
  wire start_prot = cmd_wr && (seq_r == fcs_pkg::SEQ_RP) && prot_step;
  wire start_op = start_prog || start_chip || start_sect || start_prot;
  wire id_enter = cmd_wr && (seq_r == fcs_pkg::SEQ_U2) && at_u1
    && (bus_wdata == fcs_pkg::DAT_ID_IN); // RULE_07
  // exit is accepted as a lone write or as the third write of the long form
  wire id_exit = cmd_wr && (bus_wdata == fcs_pkg::DAT_ID_OUT)
    && ((seq_r == fcs_pkg::SEQ_IDLE) || ((seq_r == fcs_pkg::SEQ_U2) && at_u1)); // RULE_10

  always_comb begin
    seq_nxt = fcs_pkg::SEQ_IDLE; // RULE_24
    if (!cmd_wr) begin
      seq_nxt = key_ok ? seq_r : fcs_pkg::SEQ_IDLE; // RULE_22
    end else begin
      case (seq_r)
        fcs_pkg::SEQ_IDLE: begin
          if (is_u1) begin
            seq_nxt = fcs_pkg::SEQ_U1;
          end
        end
        fcs_pkg::SEQ_U1: begin
          if (is_u2) begin
            seq_nxt = fcs_pkg::SEQ_U2;
          end
        end
        fcs_pkg::SEQ_U2: begin
          if (at_u1 && bus_wdata == fcs_pkg::DAT_PROG) begin
            seq_nxt = fcs_pkg::SEQ_PGM;
          end else if (at_u1 && bus_wdata == fcs_pkg::DAT_ERASE) begin
            seq_nxt = fcs_pkg::SEQ_E1;
          end else if (at_u1 && bus_wdata == fcs_pkg::DAT_PROT) begin
            seq_nxt = fcs_pkg::SEQ_RP;
          end
        end
        fcs_pkg::SEQ_E1: begin
          if (is_u1) begin
            seq_nxt = fcs_pkg::SEQ_E2;
          end
        end
        fcs_pkg::SEQ_E2: begin
          if (is_u2) begin
            seq_nxt = fcs_pkg::SEQ_E3;
          end
        end
        default: seq_nxt = fcs_pkg::SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      seq_r <= fcs_pkg::SEQ_IDLE; // RULE_25
      id_mode_r <= 1'b0; // RULE_25
    end else begin
      seq_r <= seq_nxt;
      if (id_enter) begin
        id_mode_r <= 1'b1;
      end else if (id_exit) begin
        id_mode_r <= 1'b0;
      end
    end
  end

  // operation timer: busy for the full figure, erase also until the walk ends
  wire cnt_done = (cnt_r == CNT_ONE) || (cnt_r == CNT_ZERO);
  wire op_end = busy_r && cnt_done && !walk_r;
  wire [16:0] sect_lo = {1'b0, bus_addr[15:12], 12'h000};
  wire [16:0] sect_from = (sect_lo < BASE17) ? BASE17 : sect_lo;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      op_r <= fcs_pkg::OP_NONE;
      cnt_r <= CNT_ZERO;
    end else if (start_op) begin
      busy_r <= 1'b1;
      if (start_prog) begin
        op_r <= fcs_pkg::OP_PROG;
        cnt_r <= PROG_N;
      end else if (start_chip) begin
        op_r <= fcs_pkg::OP_CHIP;
        cnt_r <= CHIP_N; // RULE_01
      end else if (start_sect) begin
        op_r <= fcs_pkg::OP_SECT;
        cnt_r <= SECT_N;
      end else begin
        op_r <= fcs_pkg::OP_PROT;
        cnt_r <= PROT_N; // RULE_14
      end
    end else if (op_end) begin
      busy_r <= 1'b0;
      op_r <= fcs_pkg::OP_NONE;
    end else if (busy_r && !cnt_done) begin
      cnt_r <= cnt_r - CNT_ONE;
    end
  end

  // erase walk writes all ones one byte per cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      walk_r <= 1'b0;
      walk_ptr_r <= '0;
      walk_end_r <= '0;
    end else if (start_chip) begin
      walk_r <= 1'b1;
      walk_ptr_r <= BASE17; // RULE_01
      walk_end_r <= TOP;
    end else if (start_sect) begin
      walk_r <= 1'b1;
      walk_ptr_r <= sect_from; // RULE_17
      walk_end_r <= sect_lo + {1'b0, SECT_LEN};
    end else if (walk_r) begin
      walk_ptr_r <= walk_ptr_r + 17'h00001;
      walk_r <= (walk_ptr_r + 17'h00001) < walk_end_r;
    end
  end

  // protection is cleared only by a completed chip erase or by reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prot_r <= 1'b0;
    end else if (op_end && op_r == fcs_pkg::OP_PROT) begin
      prot_r <= 1'b1;
    end else if (op_end && op_r == fcs_pkg::OP_CHIP) begin
      prot_r <= 1'b0; // RULE_13
    end
  end

  // array write port
  wire mem_we = start_prog || walk_r;
  wire [16:0] waddr_abs = walk_r ? walk_ptr_r : {1'b0, bus_addr};
  wire [16:0] waddr_off = waddr_abs - BASE17;
  wire [7:0] mem_wdata = walk_r ? fcs_pkg::ERASED : bus_wdata; // RULE_02
  wire [16:0] raddr_off = {1'b0, bus_addr} - BASE17;

  fcs_mem #(
    .AW(16),
    .DEPTH(DEPTH)
  ) u_mem (
    .core_clk(core_clk),
    .we(mem_we),
    .waddr(waddr_off[15:0]),
    .wdata(mem_wdata),
    .raddr(raddr_off[15:0]),
    .rdata(mem_q)
  );

  // read path: stage 1 picks the source, stage 2 registers the answer
  wire rd_busy = bus_rd && busy_r;
  wire rd_block = bus_rd && par_s2_r && prot_r; // RULE_11
  wire id_maker = id_mode_r && (bus_addr == fcs_pkg::ADDR_ID_MAKER);
  wire id_macro = id_mode_r && (bus_addr == fcs_pkg::ADDR_ID_MACRO);
  wire id_size = id_mode_r && (bus_addr == fcs_pkg::ADDR_ID_SIZE); // RULE_08
  wire id_prot = id_mode_r && (bus_addr == fcs_pkg::ADDR_PROT); // RULE_09
  wire [7:0] busy_val = {fcs_pkg::BUSY_VAL[7], tog_r, fcs_pkg::BUSY_VAL[5:0]}; // RULE_04
  wire [7:0] prot_val = prot_r ? fcs_pkg::PROT_ON_VAL : fcs_pkg::PROT_OFF_VAL;
  wire [7:0] alt_val = rd_busy ? busy_val
    : rd_block ? fcs_pkg::BLOCKED_VAL
    : id_maker ? MAKER_CODE
    : id_macro ? MACRO_CODE
    : id_size ? fcs_pkg::fcs_size_code(ARRAY_KB)
    : id_prot ? prot_val
    : fcs_pkg::BLOCKED_VAL;
  wire use_alt = rd_busy || rd_block || id_maker || id_macro || id_size || id_prot;
  wire [1:0] rsel = use_alt ? 2'h1 : (in_array ? 2'h0 : 2'h2);
  wire [7:0] rd_pick = (rsel_p1_r == 2'h0) ? mem_q : alt_p1_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tog_r <= 1'b1;
    end else if (start_op) begin
      tog_r <= 1'b1; // RULE_05
    end else if (rd_busy) begin
      tog_r <= !tog_r; // RULE_04
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_p1_r <= 1'b0;
      rsel_p1_r <= 2'h0;
      alt_p1_r <= 8'h00;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rd_p1_r <= bus_rd;
      rsel_p1_r <= rsel;
      alt_p1_r <= alt_val; // RULE_15
      rvalid_r <= rd_p1_r;
      if (rd_p1_r) begin
        rdata_r <= rd_pick;
      end
    end
  end

  // age of a running protect operation, kept only to bound its length
  logic [fcs_pkg::CNT_W-1:0] prot_age_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prot_age_r <= CNT_ZERO;
    end else if (start_prot) begin
      prot_age_r <= CNT_ZERO;
    end else if (busy_r && op_r == fcs_pkg::OP_PROT) begin
      prot_age_r <= prot_age_r + CNT_ONE;
    end
  end

  assign bus_rdata = rdata_r;
  assign bus_rvalid = rvalid_r;
  assign flash_busy = busy_r;
  assign array_unavail = busy_r; // RULE_15
  assign read_protected = prot_r;
  assign serial_cmd_refuse = prot_r; // RULE_12
  assign wdt_hold_off = ldr_s2_r; // RULE_20

  a_busy_no_seq: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_03
    (busy_r && bus_wr) |=> (seq_r == fcs_pkg::SEQ_IDLE) && $stable(op_r))
    else $error("command write accepted while busy");
  a_key_gate: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_22
    (bus_wr && !key_ok) |=> (seq_r == fcs_pkg::SEQ_IDLE) && !$rose(busy_r))
    else $error("command write taken without enabling key");
  a_toggle_start: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_05
    $rose(busy_r) |-> tog_r)
    else $error("toggle bit not one at operation start");
  a_toggle_read: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_04
    (bus_rd && busy_r) |-> ##2 (bus_rdata[fcs_pkg::TOG_BIT] == $past(tog_r, 2)) && bus_rvalid)
    else $error("busy read did not carry toggle bit");
  a_erase_ones: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_02
    walk_r |-> mem_we && (mem_wdata == fcs_pkg::ERASED))
    else $error("erase walk wrote non-erased value");
  a_prot_time: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_14
    start_prot |=> busy_r && (cnt_r <= PROT_N) && (op_r == fcs_pkg::OP_PROT))
    else $error("protect operation longer than allowed");
  a_prot_clear: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_13
    $fell(prot_r) |-> ($past(op_r) == fcs_pkg::OP_CHIP))
    else $error("protection cleared without chip erase");
  a_id_exit: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_10
    (id_exit && !id_enter) |=> !id_mode_r)
    else $error("id mode kept after exit command");
  a_par_block: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_11
    (bus_rd && par_s2_r && prot_r && !busy_r) |-> ##2 (bus_rdata == fcs_pkg::BLOCKED_VAL))
    else $error("protected array read in parallel mode");
  a_id_size: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_08
    (id_size && bus_rd && !busy_r && !rd_block) |-> ##2
      (bus_rdata == fcs_pkg::fcs_size_code(ARRAY_KB)))
    else $error("wrong size code in id mode");
  a_prot_bound: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_14
    (busy_r && op_r == fcs_pkg::OP_PROT) |-> (prot_age_r < PROT_N))
    else $error("protect operation outlasted its limit");
  a_unavail_busy: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_15
    (bus_rd && busy_r) |-> ##2 bus_rvalid && (bus_rdata[5:0] == fcs_pkg::BUSY_VAL[5:0]))
    else $error("array data returned during an operation");
  a_id_maker: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_07
    (id_maker && bus_rd && !busy_r && !rd_block) |-> ##2 (bus_rdata == MAKER_CODE))
    else $error("wrong maker code in id mode");
  a_walk_range: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_17
    walk_r |-> (walk_ptr_r >= BASE17) && (walk_ptr_r < walk_end_r))
    else $error("erase walk left its range");
endmodule

// [shared/fcs_pkg.sv]
// constants, command codes and state encodings of the flash command sequencer
// assumes one 50 MHz clock and an 8-bit cpu data bus with 16-bit addresses
// Overview of operation
// [RULE_01] chip erase clears the whole array, taking about thirty milliseconds
// [RULE_02] after chip erase every array byte reads back as all ones
// [RULE_03] no new command sequence is accepted while a chip erase runs
// [RULE_04] while busy, each read of an address inverts bit 6 against the last
// [RULE_05] the first toggle bit read after an operation starts returns one
// [RULE_06] software polls one address until two reads match before continuing
// [RULE_07] id entry maps maker code and macro code onto the first two id addresses
// [RULE_08] in id mode the size address returns the array size code
// [RULE_09] in id mode the protect address reads all ones only when unprotected
// [RULE_10] id exit restores normal array reads everywhere
// [RULE_11] read protection blocks array reads in parallel programming mode
// [RULE_12] read protection refuses serial flash-write and ram-loader commands
// [RULE_13] only a chip erase clears read protection; here reset clears it as well
// [RULE_14] protect setting ends within forty microseconds, commands locked till then
// [RULE_15] array reads and fetches are unavailable while an operation is active
// [RULE_16] command sequences are issued from boot rom or ram, not from flash
// [RULE_17] byte writes and reads, whole or 4 kbyte sector erase
// [RULE_18] software erases a location before programming it again
// [RULE_19] software disables interrupts and sets the key to 0011b, then 1100b
// [RULE_20] in loader mode the watchdog is held disabled before ram code runs
// [RULE_21] sequence addresses compare only the low 12 bits, targets excepted
// [RULE_22] without the enabling key every command write is ignored
// [RULE_23] byte program takes address and data from the fourth write
// [RULE_24] a write not matching the next step returns the decoder to idle
// [RULE_25] reset clears the decoder and id mode, leaving normal reads
package fcs_pkg;
  localparam int CLK_MHZ = 50;
  localparam int CHIP_ERASE_MS = 30;
  localparam int SECT_ERASE_MS = 30;
  localparam int PROG_US = 40;
  localparam int PROT_US = 40;
  localparam int ERASE_CYC = CHIP_ERASE_MS * 1000 * CLK_MHZ;
  localparam int SECT_CYC = SECT_ERASE_MS * 1000 * CLK_MHZ;
  localparam int PROG_CYC = PROG_US * CLK_MHZ;
  localparam int PROT_CYC = PROT_US * CLK_MHZ;
  localparam int CNT_W = 22;
  localparam int ARRAY_KB = 60;
  localparam int SECT_BYTES = 4096;

  localparam logic [3:0] KEY_ENABLE = 4'h3;
  localparam logic [11:0] ADDR_U1 = 12'h555;
  localparam logic [11:0] ADDR_U2 = 12'hAAA;
  localparam logic [7:0] DAT_U1 = 8'hAA;
  localparam logic [7:0] DAT_U2 = 8'h55;
  localparam logic [7:0] DAT_PROG = 8'hA0;
  localparam logic [7:0] DAT_ERASE = 8'h80;
  localparam logic [7:0] DAT_CHIP = 8'h10;
  localparam logic [7:0] DAT_SECT = 8'h30;
  localparam logic [7:0] DAT_ID_IN = 8'h90;
  localparam logic [7:0] DAT_ID_OUT = 8'hF0;
  localparam logic [7:0] DAT_PROT = 8'hA5;
  localparam logic [15:0] ADDR_PROT = 16'hFF7F;
  localparam logic [7:0] DAT_PROT_CONF = 8'h00;
  localparam logic [15:0] ADDR_ID_MAKER = 16'hF000;
  localparam logic [15:0] ADDR_ID_MACRO = 16'hF001;
  localparam logic [15:0] ADDR_ID_SIZE = 16'hF002;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] PROT_OFF_VAL = 8'hFF;
  localparam logic [7:0] PROT_ON_VAL = 8'h00;
  localparam logic [7:0] BLOCKED_VAL = 8'h00;
  localparam logic [7:0] BUSY_VAL = 8'hFF;
  localparam int TOG_BIT = 6;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_U1 = 3'b001,
    SEQ_U2 = 3'b010,
    SEQ_PGM = 3'b011,
    SEQ_E1 = 3'b100,
    SEQ_E2 = 3'b101,
    SEQ_E3 = 3'b110,
    SEQ_RP = 3'b111
  } fcs_seq_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_PROG = 3'b001,
    OP_SECT = 3'b010,
    OP_CHIP = 3'b011,
    OP_PROT = 3'b100
  } fcs_op_t;

  function automatic logic [7:0] fcs_size_code(input int kb);
    case (kb)
      60: fcs_size_code = 8'h0E;
      48: fcs_size_code = 8'h0B;
      32: fcs_size_code = 8'h07;
      24: fcs_size_code = 8'h05;
      16: fcs_size_code = 8'h03;
      8: fcs_size_code = 8'h01;
      default: fcs_size_code = 8'h00;
    endcase
  endfunction
endpackage

// [logic/fcs_mem.sv]
// byte array of the flash: one write port, one read port with registered data
// assumes the caller serialises erase walks and programming onto the write port
`timescale 1ns/1ns
module fcs_mem #(
  parameter int AW = 16,
  parameter int DEPTH = 61440
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  // no reset: array contents are nonvolatile and keep their value
  logic [7:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// [dv/fcs_cpu_model.sv]
// cpu-side bus master that runs the flash control program from ram
// assumes one-cycle read and write strobes and one read outstanding at a time
`timescale 1ns/1ns
module fcs_cpu_model (
  input wire logic core_clk,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid,
  output logic bus_wr,
  output logic bus_rd,
  output logic [15:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic [3:0] command_enable_key
);
  // every sequence comes from this ram-resident program, never from the array
  initial begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    command_enable_key = 4'hC;
  end

  // interrupts are taken to be off before the key opens
  task automatic unlock();
    @(negedge core_clk);
    command_enable_key = 4'h3;
  endtask

  task automatic lock();
    @(negedge core_clk);
    command_enable_key = 4'hC;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    bus_wr = 1'b1;
    bus_addr = a;
    bus_wdata = d;
    @(negedge core_clk);
    bus_wr = 1'b0;
    // released lines show garbage so a stale value cannot be mistaken for a hold
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d, output bit ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    @(negedge core_clk);
    bus_rd = 1'b1;
    bus_addr = a;
    @(negedge core_clk);
    bus_rd = 1'b0;
    bus_addr = ~a;
    for (n = 0; n < 4 && !ok; n++) begin
      if (bus_rvalid === 1'b1) begin
        d = bus_rdata;
        ok = 1'b1;
      end else begin
        @(negedge core_clk);
      end
    end
  endtask
endmodule

// [dv/tb_fcs_seq.sv]
// self-checking bench of the flash command sequencer
// assumes the cpu model drives the bus and the array starts unknown
`timescale 1ns/1ns
module tb_fcs_seq;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
  localparam logic [7:0] MACRO = 8'h3C; // arbitrary value
  logic core_clk;
  logic nrst;
  logic par_mode_pin;
  logic loader_mode_pin;
  logic bus_wr;
  logic bus_rd;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  logic bus_rvalid;
  logic [3:0] command_enable_key;
  logic flash_busy;
  logic array_unavail;
  logic read_protected;
  logic serial_cmd_refuse;
  logic wdt_hold_off;
  int err_total = 0;
  int samples_checked = 0;
  int busy_cyc = 0;
  logic [7:0] exp_q[$];
  bit chk_q[$];
  logic [15:0] pa[3];
  logic [7:0] pd[3];

  fcs_seq #(.ARRAY_KB(60), .CHIP_CYC(64), .SECT_CYC(64), .MAKER_CODE(MAKER),
    .MACRO_CODE(MACRO)) u_fcs_seq (.core_clk(core_clk), .nrst(nrst), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .command_enable_key(command_enable_key),
    .par_mode_pin(par_mode_pin), .loader_mode_pin(loader_mode_pin), .flash_busy(flash_busy),
    .array_unavail(array_unavail), .read_protected(read_protected),
    .serial_cmd_refuse(serial_cmd_refuse), .wdt_hold_off(wdt_hold_off));

  fcs_cpu_model u_fcs_cpu_model (.core_clk(core_clk), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .command_enable_key(command_enable_key));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic final_report();
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic hang();
    err_total++;
    final_report();
  endtask

  task automatic rdq(input logic [15:0] a, input logic [7:0] e, input bit k,
    output logic [7:0] d);
    bit ok;
    exp_q.push_back(e);
    chk_q.push_back(k);
    u_fcs_cpu_model.rd(a, d, ok);
    if (!ok) hang();
  endtask

  task automatic rd_exp(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    rdq(a, e, 1'b1, d);
  endtask

  task automatic cmd(input logic [15:0] a3, input logic [7:0] d3);
    logic [3:0] hi;
    // upper address bits vary: only the low twelve may be decoded
    hi = 4'($urandom);
    u_fcs_cpu_model.wr({hi, 12'h555}, 8'hAA);
    u_fcs_cpu_model.wr({hi, 12'hAAA}, 8'h55);
    u_fcs_cpu_model.wr(a3, d3);
  endtask

  // reads one address until two answers match
  task automatic poll();
    logic [7:0] p;
    logic [7:0] c;
    int n;
    rdq(16'h2000, 8'h00, 1'b0, p);
    check(p, 8'hFF);
    for (n = 0; n < 25000; n++) begin
      rdq(16'h2000, 8'h00, 1'b0, c);
      if (c === p) break;
      if ((c | 8'h40) === 8'hFF && (p | 8'h40) === 8'hFF) check(c ^ p, 8'h40);
      p = c;
    end
    if (n == 25000) hang();
    check(32'(flash_busy), 0);
  endtask

  // the queue holds one note per read; only noted values are compared
  always @(negedge core_clk) begin
    if (bus_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0);
      end else if (chk_q.pop_front()) begin
        check(bus_rdata, exp_q.pop_front());
      end else begin
        void'(exp_q.pop_front());
      end
    end
    if (flash_busy === 1'b1) begin
      busy_cyc++;
      check(32'(array_unavail), 1);
    end
  end

  initial begin
    nrst = 1'b0;
    par_mode_pin = 1'b0;
    loader_mode_pin = 1'b0;
    void'($urandom(98));
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    check({flash_busy, read_protected, serial_cmd_refuse, wdt_hold_off}, 4'h0);
    cmd(16'h0555, 8'hA5);
    u_fcs_cpu_model.wr(16'hFF7F, 8'h00);
    repeat (4) @(negedge core_clk);
    check({flash_busy, read_protected}, 2'b00);
    u_fcs_cpu_model.unlock();
    busy_cyc = 0;
    cmd(16'h0555, 8'hA5);
    u_fcs_cpu_model.wr(16'hFF7F, 8'h00);
    // a chip erase issued mid-operation must be dropped
    cmd(16'h0555, 8'h80);
    cmd(16'h0555, 8'h10);
    poll();
    check(32'(busy_cyc <= fcs_pkg::PROT_CYC), 1);
    repeat (3) @(negedge core_clk);
    check({flash_busy, read_protected, serial_cmd_refuse}, 3'b011);
    par_mode_pin = 1'b1;
    repeat (4) @(negedge core_clk);
    rd_exp(16'h3000, 8'h00);
    par_mode_pin = 1'b0;
    repeat (4) @(negedge core_clk);
    cmd(16'h0555, 8'h90);
    rd_exp(16'hF000, MAKER);
    rd_exp(16'hF001, MACRO);
    rd_exp(16'hF002, 8'h0E);
    rd_exp(16'hFF7F, 8'h00);
    cmd(16'h0555, 8'h80);
    cmd(16'h5123, 8'h30);
    poll();
    u_fcs_cpu_model.wr(16'h0123, 8'hF0);
    check(32'(read_protected), 1);
    cmd(16'h0555, 8'h80);
    cmd(16'h0555, 8'h10);
    cmd(16'h0555, 8'hA5);
    u_fcs_cpu_model.wr(16'hFF7F, 8'h00);
    poll();
    check(32'(read_protected), 0);
    for (int i = 0; i < 4; i++) rd_exp(16'h1000 + 16'($urandom % 32'hF000), 8'hFF);
    // a wrong third step must send the decoder back to idle
    u_fcs_cpu_model.wr(16'h0555, 8'hAA);
    u_fcs_cpu_model.wr(16'h0AAA, 8'h55);
    u_fcs_cpu_model.wr(16'h0123, 8'hA0);
    u_fcs_cpu_model.wr(16'h4000, 8'h12);
    repeat (4) @(negedge core_clk);
    check(32'(flash_busy), 0);
    rd_exp(16'h4000, 8'hFF);
    // targets are all freshly erased before programming
    for (int i = 0; i < 3; i++) begin
      pa[i] = (i == 0) ? 16'hF000 : {4'(i + 5), 12'($urandom)};
      pd[i] = 8'($urandom);
      cmd(16'h0555, 8'hA0);
      u_fcs_cpu_model.wr(pa[i], pd[i]);
      poll();
    end
    for (int i = 0; i < 3; i++) rd_exp(pa[i], pd[i]);
    cmd(16'h0555, 8'h80);
    cmd(16'h6ABC, 8'h30);
    poll();
    rd_exp(pa[1], 8'hFF);
    rd_exp(pa[2], pd[2]);
    cmd(16'h0555, 8'h90);
    rd_exp(16'hF000, MAKER);
    rd_exp(16'hFF7F, 8'hFF);
    cmd(16'h0555, 8'hF0);
    rd_exp(16'hF000, pd[0]);
    cmd(16'h0555, 8'h90);
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    check({flash_busy, read_protected}, 2'b00);
    nrst = 1'b1;
    rd_exp(16'hF000, pd[0]);
    loader_mode_pin = 1'b1;
    repeat (4) @(negedge core_clk);
    check(32'(wdt_hold_off), 1);
    u_fcs_cpu_model.lock();
    repeat (6) @(negedge core_clk);
    check(exp_q.size(), 0);
    final_report();
  end
endmodule
